// ### src/sqm_pkg.sv
/*
 * Shared constants, field layouts and carriers for the slicer error
 * quality monitor: slicer levels, register map, timing, scaling function.
 * Assumes a single core clock and one received symbol per valid strobe.
 */
// Functional notes
// - ideal levels -128,0,128 at 100M; -128,-64,0,64,128 at gigabit.
// - decision thresholds -64,64 at 100M; -96,-32,32,96 at gigabit.
// - slicer error clamped to +-32 gigabit, +-64 at 100M.
// - filters run only while the quality enable bit is set.
// - basic method filters the absolute value of the slicer error.
// - filter adds back (error - filter); gigabit error doubled first.
// - square-select squares the scaled error instead of absolute value.
// - add-back term divided by two to the filter_shift power.
// - filtered value latched every 1 ms, i.e. every 125000 symbols.
// - capture_strobe self-clears; latched mean of chosen pair readable.
// - mse = filtered >> mse_scale_shift, saturating at 511.
// - after capture the scaled result sits in the mse result register.
// - worst mse since last mse read held separately; read restarts it.
// - all registers live in management device address 1.
package sqm_pkg;
    localparam int PAIRS = 4;
    localparam int FRAC_W = 8;
    localparam int COND_W = 13;
    localparam int FILT_W = COND_W + FRAC_W;

    // slicer reference levels, thresholds and error bounds, 10-bit signed; mse limit 9-bit unsigned
    localparam logic signed [9:0] LVL_OUT = 10'sh080;
    localparam logic signed [9:0] LVL_IN = 10'sh040;
    localparam logic signed [9:0] THR_FAST = 10'sh040;
    localparam logic signed [9:0] THR_GIG_OUT = 10'sh060;
    localparam logic signed [9:0] THR_GIG_IN = 10'sh020;
    localparam logic signed [9:0] ERR_GIG_MAX = 10'sh020;
    localparam logic signed [9:0] ERR_FAST_MAX = 10'sh040;
    localparam logic [8:0] MSE_MAX = 9'h1FF;

    // management space
    localparam logic [4:0] MMD_DEV = 5'h01;
    localparam logic [15:0] REG_CFG = 16'h00E0;
    localparam logic [15:0] REG_MEAN = 16'h00E1;
    localparam logic [15:0] REG_MSE = 16'h00E2;
    localparam logic [15:0] REG_WORST = 16'h00E3;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // timing: one symbol per 8 ns at the line rate
    localparam int SYM_PERIOD_NS = 8;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_SYMBOLS = MS_PERIOD_NS / SYM_PERIOD_NS;

    typedef struct packed {
        logic capture_strobe;
        logic [2:0] rsvd;
        logic [1:0] pair_select;
        logic [3:0] mse_scale_shift;
        logic [3:0] filter_shift;
        logic squ;
        logic en;
    } sqm_cfg_t;

    typedef struct packed {
        logic valid;
        logic gig;
        logic [PAIRS-1:0][8:0] sample;
    } sqm_sym_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sqm_bus_t;

    // scale a filtered value into the bounded mse figure
    function automatic logic [8:0] sqm_scale(input logic [COND_W-1:0] v,
                                             input logic [3:0] sh);
        logic [COND_W-1:0] q;
        q = v >> sh;
        if (q > {4'h0, MSE_MAX}) begin
            return MSE_MAX;
        end
        return q[8:0];
    endfunction : sqm_scale
endpackage : sqm_pkg

// ### src/sqm_slicer.sv
/*
 * Per-pair slicer: decides the symbol, forms the bounded error and
 * conditions it (absolute, doubled at gigabit, optionally squared).
 * Assumes samples come from logic on core_clk; output is one cycle late.
 */
module sqm_slicer
    import sqm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic gig,
    input wire logic square_sel,
    input wire logic [8:0] sample,
    output logic [COND_W-1:0] cond,
    output logic cond_valid
);
    logic signed [9:0] s;
    logic signed [9:0] lvl;
    logic signed [9:0] err;
    logic signed [9:0] bound;
    logic [6:0] mag;
    logic [6:0] scaled;
    logic [COND_W-1:0] next_cond;

    // decision and error; thresholds sit midway between levels
    always_comb begin
        s = {sample[8], sample};
        if (gig) begin
            if (s > THR_GIG_OUT) lvl = LVL_OUT;
            else if (s > THR_GIG_IN) lvl = LVL_IN;
            else if (s >= -THR_GIG_IN) lvl = 10'sh000;
            else if (s >= -THR_GIG_OUT) lvl = -LVL_IN;
            else lvl = -LVL_OUT;
        end else begin
            if (s > THR_FAST) lvl = LVL_OUT;
            else if (s >= -THR_FAST) lvl = 10'sh000;
            else lvl = -LVL_OUT;
        end
        bound = gig ? ERR_GIG_MAX : ERR_FAST_MAX;
        err = s - lvl;
        // clamp: outer levels have an open side
        if (err > bound) err = bound;
        else if (err < -bound) err = -bound;
        mag = err[9] ? 7'(-err) : err[6:0];
        scaled = gig ? {mag[5:0], 1'b0} : mag;
        if (square_sel) next_cond = COND_W'({6'h00, scaled} * {6'h00, scaled});
        else next_cond = {6'h00, scaled};
    end

    // register the conditioned error
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cond <= '0;
            cond_valid <= 1'b0;
        end else begin
            cond <= next_cond;
            cond_valid <= sample_valid;
        end
    end

    AST_ERR_BOUND: assert property (@(posedge core_clk) disable iff (!reset_n)
        sample_valid |=> cond <= (square_sel ? 13'h1000 : 13'h0040))
        else $error("conditioned error beyond bound");
endmodule : sqm_slicer

// ### src/sqm_monitor.sv
/*
 * Slicer error quality monitor: four per-pair low-pass filters, a 1 ms
 * latch, capture into mean and mse result registers, worst-case tracking.
 * Assumes symbols and register strobes arrive from logic on core_clk.
 */
module sqm_monitor
    import sqm_pkg::*;
#(
    parameter int MS_COUNT = MS_SYMBOLS
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sqm_sym_t sym,
    input wire sqm_bus_t bus,
    output logic [15:0] rd_data
);
    logic [PAIRS-1:0][COND_W-1:0] cond;
    logic [PAIRS-1:0] cond_valid;
    sqm_cfg_t cfg;
    sqm_cfg_t next_cfg;
    sqm_cfg_t wcfg;
    logic [PAIRS-1:0][FILT_W-1:0] filt;
    logic [PAIRS-1:0][FILT_W-1:0] next_filt;
    logic signed [FILT_W+1:0] diff [PAIRS];
    logic signed [FILT_W+1:0] step [PAIRS];
    logic signed [FILT_W+1:0] sum [PAIRS];
    logic [PAIRS-1:0][COND_W-1:0] latched;
    logic [PAIRS-1:0][COND_W-1:0] next_latched;
    logic [16:0] sym_cnt;
    logic [16:0] next_sym_cnt;
    logic ms_tick;
    logic [COND_W-1:0] mean_reg;
    logic [COND_W-1:0] next_mean;
    logic [8:0] mse_reg;
    logic [8:0] next_mse;
    logic [8:0] worst_reg;
    logic [8:0] next_worst;
    logic [8:0] cap_mse;
    logic [15:0] next_rd_data;
    logic dev_hit;
    logic wr_cfg;
    logic capture;
    logic rd_mse;

    // one slicer per pair, each with its own conditioned stream
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        sqm_slicer u_slicer (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .sample_valid(sym.valid),
            .gig(sym.gig),
            .square_sel(cfg.squ),
            .sample(sym.sample[p]),
            .cond(cond[p]),
            .cond_valid(cond_valid[p])
        );
    end

    // register hit on device 1 only; shared by write, capture and read decode
    function automatic logic reg_hit(input sqm_bus_t b, input logic [15:0] a);
        return (b.dev == MMD_DEV) && (b.addr == a);
    endfunction : reg_hit

    // decode: only device address 1 answers, others are ignored
    assign dev_hit = (bus.dev == MMD_DEV);
    assign wcfg = sqm_cfg_t'(bus.wdata);
    assign wr_cfg = bus.wr && reg_hit(bus, REG_CFG);
    assign capture = wr_cfg && wcfg.capture_strobe;
    assign rd_mse = bus.rd && reg_hit(bus, REG_MSE);

    // configuration: the capture bit is never stored, so it reads back 0
    always_comb begin
        next_cfg = cfg;
        if (wr_cfg) begin
            next_cfg = wcfg;
            next_cfg.capture_strobe = 1'b0;
            next_cfg.rsvd = 3'h0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= sqm_cfg_t'(CFG_RESET);
        end else begin
            cfg <= next_cfg;
        end
    end

    // first-order low-pass per pair; fraction bits keep small steps alive
    always_comb begin
        for (int p = 0; p < PAIRS; p++) begin
            diff[p] = $signed({2'b00, cond[p], {FRAC_W{1'b0}}})
                    - $signed({2'b00, filt[p]});
            step[p] = diff[p] >>> cfg.filter_shift;
            sum[p] = $signed({2'b00, filt[p]}) + step[p];
            next_filt[p] = filt[p];
            if (cfg.en && cond_valid[p]) begin
                next_filt[p] = sum[p][FILT_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            filt <= '0;
        end else begin
            filt <= next_filt;
        end
    end

    // millisecond symbol counter; stands still while disabled
    assign ms_tick = cfg.en && cond_valid[0] && (sym_cnt == 17'(MS_COUNT - 1));

    always_comb begin
        next_sym_cnt = sym_cnt;
        next_latched = latched;
        if (cfg.en && cond_valid[0]) begin
            next_sym_cnt = ms_tick ? 17'h00000 : sym_cnt + 17'h00001;
        end
        if (ms_tick) begin
            for (int p = 0; p < PAIRS; p++) begin
                next_latched[p] = filt[p][FILT_W-1:FRAC_W];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sym_cnt <= '0;
            latched <= '0;
        end else begin
            sym_cnt <= next_sym_cnt;
            latched <= next_latched;
        end
    end

    // capture uses the scale written in the same cycle
    assign cap_mse = sqm_scale(latched[wcfg.pair_select], wcfg.mse_scale_shift);

    // results; a capture in the read cycle still counts for worst case
    always_comb begin
        next_mean = mean_reg;
        next_mse = mse_reg;
        next_worst = worst_reg;
        if (rd_mse) begin
            next_worst = 9'h000;
        end
        if (capture) begin
            next_mean = latched[wcfg.pair_select];
            next_mse = cap_mse;
            if (cap_mse > next_worst) begin
                next_worst = cap_mse;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mean_reg <= '0;
            mse_reg <= '0;
            worst_reg <= '0;
        end else begin
            mean_reg <= next_mean;
            mse_reg <= next_mse;
            worst_reg <= next_worst;
        end
    end

    // read data stand one cycle only; unmapped or foreign reads give 0
    always_comb begin
        next_rd_data = 16'h0000;
        if (bus.rd && dev_hit) begin
            if (bus.addr == REG_CFG) begin
                next_rd_data = 16'(cfg);
            end else if (bus.addr == REG_MEAN) begin
                next_rd_data = {3'h0, mean_reg};
            end else if (bus.addr == REG_MSE) begin
                next_rd_data = {7'h00, mse_reg};
            end else if (bus.addr == REG_WORST) begin
                next_rd_data = {7'h00, worst_reg};
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    AST_CFG_NO_CAPTURE: assert property (
        capture |=> (rd_data == 16'h0000) && !cfg.capture_strobe
                 && (mean_reg == $past(latched[wcfg.pair_select])))
        else $error("capture did not self-clear or load mean");

    AST_MSE_VALUE: assert property (
        capture |=> mse_reg == sqm_scale($past(latched[wcfg.pair_select]),
                                         $past(wcfg.mse_scale_shift)))
        else $error("mse result not scaled from latched value");

    AST_MSE_LIMIT: assert property (
        capture && ((latched[wcfg.pair_select] >> wcfg.mse_scale_shift) > 13'h01FF)
        |=> mse_reg == MSE_MAX)
        else $error("mse did not saturate at 511");

    AST_WORST_TRACK: assert property (
        capture && !rd_mse |=> (worst_reg >= mse_reg) && (worst_reg >= $past(worst_reg)))
        else $error("worst case dropped below a capture");

    AST_WORST_RESTART: assert property (
        rd_mse && !capture |=> worst_reg == 9'h000)
        else $error("worst case not restarted by mse read");

    AST_HOLD_OFF: assert property (
        !cfg.en |=> $stable(filt) && $stable(sym_cnt))
        else $error("filter moved while disabled");

    AST_MS_LATCH: assert property (
        ms_tick |=> (latched[0] == $past(filt[0][FILT_W-1:FRAC_W]))
                 && (latched[3] == $past(filt[3][FILT_W-1:FRAC_W])) && (sym_cnt == 17'h00000))
        else $error("millisecond latch missed");

    AST_NO_EARLY_LATCH: assert property (
        !ms_tick |=> $stable(latched))
        else $error("latched value changed off the millisecond");

    AST_FILT_BOUND: assert property (
        filt[0][FILT_W-1:FRAC_W] <= 13'h1000)
        else $error("filter exceeded largest conditioned error");

    AST_FILT_STEP: assert property (
        cfg.en && cond_valid[1] && (cfg.filter_shift == 4'h0)
        |=> filt[1] == {$past(cond[1]), 8'h00})
        else $error("unit weight filter did not follow input");

    AST_READ_ONE: assert property (
        !(bus.rd && dev_hit) |=> rd_data == 16'h0000)
        else $error("read data outside read answer cycle");

    AST_FOREIGN_WR: assert property (
        bus.wr && !dev_hit |=> $stable(cfg))
        else $error("write to other device changed config");

    // register view, hold, counter and latch checks
    AST_CFG_WRITE: assert property (
        wr_cfg |=> 16'(cfg) == {4'h0, $past(bus.wdata[11:0])})
        else $error("config write not stored with strobe cleared");

    AST_CFG_HOLD: assert property (
        !wr_cfg |=> $stable(cfg))
        else $error("config changed without a write");

    AST_RESULT_HOLD: assert property (
        !capture |=> $stable(mean_reg) && $stable(mse_reg))
        else $error("result changed without a capture");

    AST_WORST_SET: assert property (
        capture && rd_mse |=> worst_reg == mse_reg)
        else $error("capture in mse read cycle lost");

    AST_WORST_HOLD: assert property (
        !capture && !rd_mse |=> $stable(worst_reg))
        else $error("worst case moved without capture or read");

    AST_RD_CFG: assert property (
        bus.rd && reg_hit(bus, REG_CFG) |=> rd_data == 16'($past(cfg)))
        else $error("config read data wrong");

    AST_RD_MEAN: assert property (
        bus.rd && reg_hit(bus, REG_MEAN) |=> rd_data == {3'h0, $past(mean_reg)})
        else $error("mean read data wrong");

    AST_RD_WORST: assert property (
        bus.rd && reg_hit(bus, REG_WORST) |=> rd_data == {7'h00, $past(worst_reg)})
        else $error("worst read data wrong");

    AST_CNT_RANGE: assert property (
        sym_cnt < 17'(MS_COUNT))
        else $error("symbol counter passed the millisecond");

    AST_CNT_STEP: assert property (
        cfg.en && cond_valid[0] && !ms_tick |=> sym_cnt == $past(sym_cnt) + 17'h00001)
        else $error("symbol counter skipped a symbol");

    AST_IDLE_HOLD: assert property (
        !cond_valid[2] |=> $stable(filt[2]))
        else $error("filter moved without a symbol");

    AST_MS_LATCH_MID: assert property (
        ms_tick |=> (latched[1] == $past(filt[1][FILT_W-1:FRAC_W]))
                 && (latched[2] == $past(filt[2][FILT_W-1:FRAC_W])))
        else $error("millisecond latch missed a middle pair");

    COV_CAPTURE: cover property (capture ##1 bus.rd && dev_hit && bus.addr == REG_MSE);
    COV_FROZEN: cover property (!cfg.en && cond_valid[0]);
    COV_SATURATE: cover property (capture ##1 mse_reg == MSE_MAX);
    COV_MS_TICK: cover property (ms_tick);
    COV_READ_CAPTURE: cover property (rd_mse && capture);
endmodule : sqm_monitor

// ### sim/testbench.sv
/*
 * Self-checking bench for the slicer error quality monitor top.
 * Assumes the monitor is built with a shortened millisecond count and
 * that the bench alone drives the symbol link and the register port.
 */
module testbench import sqm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // short latch period keeps the run brief
    localparam int MS_CNT = 16;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    sqm_sym_t sym = '0;
    sqm_bus_t bus = '0;
    logic [15:0] rd_data;
    int error_cnt = 0;
    int comparisons = 0;
    // per-pair samples, chosen on thresholds and past the error bound
    int fast_s[4] = '{100, -64, 200, -65};
    int gig_s[4] = '{200, 33, -32, -97};

    sqm_monitor #(.MS_COUNT(MS_CNT)) sqm_monitor_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sym(sym),
        .bus(bus),
        .rd_data(rd_data)
    );

    always #2 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // bus tasks are entered just after a rising edge
    task automatic bus_wr(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d);
        bus.wr <= 1'b1;
        bus.dev <= dev;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        // let an edge pass so a following write never retimes the strobe
        @(posedge core_clk);
    endtask : bus_wr

    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic bus_rd(input logic [4:0] dev, input logic [15:0] a, output logic [15:0] d);
        bus.rd <= 1'b1;
        bus.dev <= dev;
        bus.addr <= a;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        d = rd_data;
        @(posedge core_clk);
    endtask : bus_rd

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        bus_rd(MMD_DEV, a, d);
        chk(what, exp, d);
    endtask : rd_chk

    // bit order follows the configuration carrier
    function automatic logic [15:0] cfg(input logic cap, input logic [1:0] p, input logic [3:0] sc,
        input logic [3:0] kp, input logic sq, input logic en);
        return {cap, 3'h0, p, sc, kp, sq, en};
    endfunction : cfg

    // conditioned error worked out from levels, thresholds and bounds
    function automatic logic [15:0] exp_cond(input logic g, input logic q, input int s);
        int lvl;
        int e;
        int lim;
        if (g) begin
            lvl = s > 96 ? 128 : s > 32 ? 64 : s >= -32 ? 0 : s >= -96 ? -64 : -128;
        end else begin
            lvl = s > 64 ? 128 : s >= -64 ? 0 : -128;
        end
        lim = g ? 32 : 64;
        e = s - lvl;
        e = e > lim ? lim : e < -lim ? -lim : e;
        e = e < 0 ? -e : e;
        e = g ? e * 2 : e;
        e = q ? e * e : e;
        return e[15:0];
    endfunction : exp_cond

    // valid held high for n symbols, then pipeline allowed to drain
    task automatic feed(input logic g, input int s[4], input int n);
        sym.gig <= g;
        foreach (s[i]) sym.sample[i] <= s[i][8:0];
        sym.valid <= 1'b1;
        repeat (n) @(posedge core_clk);
        sym.valid <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : feed

    task automatic means(input logic g, input logic q, input int s[4], input logic [3:0] kp,
        input logic en, input int off);
        for (int p = 0; p < 4; p++) begin
            bus_wr(MMD_DEV, REG_CFG, cfg(1'b1, 2'(p), 4'h0, kp, q, en));
            rd_chk(REG_MEAN, exp_cond(g, q, s[p]) - 16'(off), "mean");
        end
    endtask : means

    task automatic t_regs;
        logic [15:0] d;
        rd_chk(REG_CFG, CFG_RESET, "cfg reset");
        rd_chk(REG_MEAN, 16'h0000, "mean reset");
        rd_chk(REG_MSE, 16'h0000, "mse reset");
        rd_chk(REG_WORST, 16'h0000, "worst reset");
        bus_wr(5'h02, REG_CFG, 16'h0FFF);
        bus_wr(MMD_DEV, 16'h00E4, 16'hFFFF);
        rd_chk(REG_CFG, 16'h0000, "cfg other device");
        bus_rd(5'h02, REG_CFG, d);
        chk("read other device", 16'h0000, d);
        rd_chk(16'h00E4, 16'h0000, "unmapped");
        bus_wr(MMD_DEV, REG_CFG, 16'hFFFF);
        rd_chk(REG_CFG, 16'h0FFF, "cfg strobe cleared");
        $display("test regs done");
    endtask : t_regs

    // second reset mid-run; halving filter stalls one lsb short of target
    task automatic t_shift;
        reset_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b0, 2'h0, 4'h0, 4'h1, 1'b0, 1'b1));
        feed(1'b0, fast_s, 64);
        means(1'b0, 1'b0, fast_s, 4'h1, 1'b1, 1);
        $display("test shift done");
    endtask : t_shift

    // unit weight first: the shift left by t_shift would hold the mean one lsb low
    task automatic t_levels;
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b0, 2'h0, 4'h0, 4'h0, 1'b0, 1'b1));
        feed(1'b0, fast_s, 40);
        means(1'b0, 1'b0, fast_s, 4'h0, 1'b1, 0);
        feed(1'b1, gig_s, 40);
        means(1'b1, 1'b0, gig_s, 4'h0, 1'b1, 0);
        $display("test levels done");
    endtask : t_levels

    // squared errors 4096/3844; worst must survive captures, not mse reads
    task automatic t_square;
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b0, 2'h0, 4'h0, 4'h0, 1'b1, 1'b1));
        feed(1'b1, gig_s, 40);
        means(1'b1, 1'b1, gig_s, 4'h0, 1'b1, 0);
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b1, 2'h0, 4'h0, 4'h0, 1'b1, 1'b1));
        rd_chk(REG_WORST, 16'h01FF, "worst after capture");
        rd_chk(REG_MSE, 16'h01FF, "mse saturated");
        rd_chk(REG_WORST, 16'h0000, "worst after read");
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b1, 2'h1, 4'h3, 4'h0, 1'b1, 1'b1));
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b1, 2'h3, 4'h4, 4'h0, 1'b1, 1'b1));
        rd_chk(REG_WORST, 16'h01E0, "worst kept");
        rd_chk(REG_MSE, 16'h00F0, "mse scaled");
        $display("test square done");
    endtask : t_square

    // disabled filters must keep their last values
    task automatic t_freeze;
        bus_wr(MMD_DEV, REG_CFG, cfg(1'b0, 2'h0, 4'h0, 4'h0, 1'b1, 1'b0));
        feed(1'b0, fast_s, 40);
        means(1'b1, 1'b1, gig_s, 4'h0, 1'b0, 0);
        bus_wr(MMD_DEV, REG_MEAN, 16'h0055);
        rd_chk(REG_MEAN, 16'h0F04, "mean read only");
        $display("test freeze done");
    endtask : t_freeze

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_shift();
        t_levels();
        t_square();
        t_freeze();
        wrap_up();
    end

    // watchdog against a stuck run
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule : testbench
